//--- verilog/rs485_half_duplex_direction_ctrl.sv
`timescale 1ns/100ps
module rs485_half_duplex_direction_ctrl #(
   parameter int unsigned OS_DIV         = rs485_dir_pkg::OS_DIV_DEF,
   parameter int unsigned REPLY_WAIT_CYC = rs485_dir_pkg::REPLY_WAIT_CYC
) (
   // Clock and reset
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RST,
   // Mode straps
   input  wire logic       I_MASTER_MODE,
   input  wire logic       I_HOST_DIR_MODE,
   input  wire logic [7:0] I_NODE_ADDR,
   // Transceiver serial lines
   input  wire logic       I_RS485_RX,
   output logic            O_RS485_TX,
   // Direction pin, shared by transceiver and connector
   input  wire logic       I_DIRECTION_CONTROL_GPIO,
   output logic            O_DIRECTION_CONTROL_GPIO,
   output logic            O_DIRECTION_CONTROL_GPIO_OE,
   // Outgoing bytes from the user
   input  wire logic [7:0] I_TX_DATA,
   input  wire logic       I_TX_LAST,
   input  wire logic       I_TX_VALID,
   output logic            O_TX_READY,
   // Received bytes to the user
   output logic      [7:0] O_RX_DATA,
   output logic            O_RX_VALID,
   input  wire logic       I_RX_READY,
   // Status
   output logic            O_TRANSMITTING,
   output logic            O_REPLY_DUE,
   output logic            O_MSG_END,
   output logic            O_NO_REPLY,
   output logic            O_RX_OVERRUN,
   output logic            O_FRAME_ERROR
);

   localparam int unsigned WW = $clog2(REPLY_WAIT_CYC + 1);

   rs485_dir_pkg::dir_state_t state_reg;
   rs485_dir_pkg::dir_state_t state_next;

   logic [15:0] os_div_cnt_reg;
   logic        os_tick;
   // Transmitter
   logic [9:0]  tx_shift_reg;
   logic [3:0]  tx_os_cnt_reg;
   logic [3:0]  tx_bit_cnt_reg;
   logic        tx_busy_reg;
   logic        tx_last_reg;
   logic        tx_line_reg;
   logic        tx_first_reg;
   logic        tx_bcast_reg;
   logic        tx_load;
   logic        tx_bit_end;
   logic        tx_frame_done;
   // Receiver
   logic [7:0]  rx_shift_reg;
   logic [3:0]  rx_os_cnt_reg;
   logic [3:0]  rx_bit_cnt_reg;
   logic        rx_busy_reg;
   logic        rx_byte_stb_reg;
   logic        rx_sample;
   logic        rx_enable;
   logic [15:0] gap_cnt_reg;
   logic        gap_hit;
   // Message tracking
   logic        keep_reg;
   logic        addressed_reg;
   logic        got_byte_reg;
   logic [WW-1:0] wait_cnt_reg;
   logic        wait_done;
   logic        deliver;
   logic        buf_ready;
   logic        dir_reg;
   logic        dir_next;
   logic        msg_end_reg;
   logic        no_reply_reg;
   logic        overrun_reg;
   logic        frame_err_reg;
   // Decode of the first byte of a message
   wire         addr_match  = (rx_shift_reg == I_NODE_ADDR);
   wire         bcast_match = (rx_shift_reg == rs485_dir_pkg::BCAST_ADDR);
   wire         slave_own   = ~I_MASTER_MODE & ~I_HOST_DIR_MODE;
   wire         first_byte  = rx_byte_stb_reg & (state_reg == rs485_dir_pkg::ST_LISTEN);

   assign os_tick = (os_div_cnt_reg == 16'(OS_DIV - 1));

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         os_div_cnt_reg <= 16'h0000;
      end else begin
         os_div_cnt_reg <= os_tick ? 16'h0000 : os_div_cnt_reg + 16'h0001;
      end
   end

   // Transmit bytes only in send state, or on host grant
   assign tx_load = ~tx_busy_reg & I_TX_VALID &
                    (I_HOST_DIR_MODE ? I_DIRECTION_CONTROL_GPIO
                                     : (state_reg == rs485_dir_pkg::ST_TX));
   assign O_TX_READY    = tx_load;
   assign tx_bit_end    = tx_busy_reg & os_tick & (tx_os_cnt_reg == 4'(rs485_dir_pkg::OS_RATE - 1));
   assign tx_frame_done = tx_bit_end & (tx_bit_cnt_reg == 4'(rs485_dir_pkg::FRAME_BITS - 1));

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         tx_shift_reg   <= 10'h3ff;
         tx_os_cnt_reg  <= 4'h0;
         tx_bit_cnt_reg <= 4'h0;
         tx_busy_reg    <= 1'b0;
         tx_last_reg    <= 1'b0;
         tx_line_reg    <= 1'b1;
      end else if (tx_load) begin
         tx_shift_reg   <= {1'b1, I_TX_DATA, 1'b0};
         tx_os_cnt_reg  <= 4'h0;
         tx_bit_cnt_reg <= 4'h0;
         tx_busy_reg    <= 1'b1;
         tx_last_reg    <= I_TX_LAST;
         tx_line_reg    <= 1'b0;
      end else if (tx_frame_done) begin
         tx_busy_reg    <= 1'b0;
         tx_line_reg    <= 1'b1;
      end else if (tx_bit_end) begin
         tx_shift_reg   <= {1'b1, tx_shift_reg[9:1]};
         tx_line_reg    <= tx_shift_reg[1];
         tx_bit_cnt_reg <= tx_bit_cnt_reg + 4'h1;
         tx_os_cnt_reg  <= 4'h0;
      end else if (tx_busy_reg & os_tick) begin
         tx_os_cnt_reg  <= tx_os_cnt_reg + 4'h1;
      end
   end

   // Master tags a broadcast from its first byte
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         tx_first_reg <= 1'b0;
         tx_bcast_reg <= 1'b0;
      end else if (state_reg != rs485_dir_pkg::ST_TX) begin
         tx_first_reg <= 1'b1;
      end else if (tx_load & tx_first_reg) begin
         tx_first_reg <= 1'b0;
         tx_bcast_reg <= (I_TX_DATA == rs485_dir_pkg::BCAST_ADDR);
      end
   end

   // Own echo is ignored; host mode listens while pin is low
   assign rx_enable = I_HOST_DIR_MODE ? ~I_DIRECTION_CONTROL_GPIO
                                      : (~dir_reg & ~tx_busy_reg);
   assign rx_sample = rx_busy_reg & os_tick & (rx_os_cnt_reg == 4'(rs485_dir_pkg::OS_MID - 1));

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         rx_shift_reg    <= 8'h00;
         rx_os_cnt_reg   <= 4'h0;
         rx_bit_cnt_reg  <= 4'h0;
         rx_busy_reg     <= 1'b0;
         rx_byte_stb_reg <= 1'b0;
         frame_err_reg   <= 1'b0;
      end else begin
         rx_byte_stb_reg <= 1'b0;
         frame_err_reg   <= 1'b0;
         if (~rx_busy_reg) begin
            if (rx_enable & ~I_RS485_RX) begin
               rx_busy_reg    <= 1'b1;
               rx_os_cnt_reg  <= 4'h0;
               rx_bit_cnt_reg <= 4'h0;
            end
         end else if (rx_sample & (rx_bit_cnt_reg == 4'h0) & I_RS485_RX) begin
            rx_busy_reg <= 1'b0;
         end else if (rx_sample & (rx_bit_cnt_reg == 4'(rs485_dir_pkg::FRAME_BITS - 1))) begin
            rx_busy_reg     <= 1'b0;
            rx_byte_stb_reg <= I_RS485_RX;
            frame_err_reg   <= ~I_RS485_RX;
         end else if (os_tick) begin
            if (rx_sample & (rx_bit_cnt_reg != 4'h0)) begin
               rx_shift_reg <= {I_RS485_RX, rx_shift_reg[7:1]};
            end
            rx_os_cnt_reg <= rx_os_cnt_reg + 4'h1;
            if (rx_os_cnt_reg == 4'(rs485_dir_pkg::OS_RATE - 1)) begin
               rx_bit_cnt_reg <= rx_bit_cnt_reg + 4'h1;
            end
         end
      end
   end

   // A quiet line closes a message
   assign gap_hit = os_tick & ~rx_busy_reg &
                    (gap_cnt_reg == 16'(rs485_dir_pkg::EOM_GAP_TICKS - 1));

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         gap_cnt_reg <= 16'h0000;
      end else if (rx_busy_reg | gap_hit) begin
         gap_cnt_reg <= 16'h0000;
      end else if (os_tick) begin
         gap_cnt_reg <= gap_cnt_reg + 16'h0001;
      end
   end

   assign wait_done = (wait_cnt_reg == WW'(REPLY_WAIT_CYC - 1));

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         wait_cnt_reg <= '0;
      end else if (state_next != state_reg) begin
         wait_cnt_reg <= '0;
      end else if (~wait_done) begin
         wait_cnt_reg <= wait_cnt_reg + WW'(1);
      end
   end

   always_comb begin
      state_next = state_reg;
      if (I_HOST_DIR_MODE) begin
         state_next = rs485_dir_pkg::ST_LISTEN;
      end else begin
         case (state_reg)
            rs485_dir_pkg::ST_LISTEN: begin
               if (I_MASTER_MODE & I_TX_VALID & ~rx_busy_reg) begin
                  state_next = rs485_dir_pkg::ST_TX;
               end else if (slave_own & rx_byte_stb_reg) begin
                  state_next = rs485_dir_pkg::ST_RX_MSG;
               end
            end
            rs485_dir_pkg::ST_RX_MSG: begin
               if (gap_hit) begin
                  state_next = addressed_reg ? rs485_dir_pkg::ST_REPLY
                                             : rs485_dir_pkg::ST_LISTEN;
               end
            end
            rs485_dir_pkg::ST_REPLY: begin
               if (rx_busy_reg | wait_done) begin
                  state_next = rs485_dir_pkg::ST_LISTEN;
               end else if (I_TX_VALID) begin
                  state_next = rs485_dir_pkg::ST_TX;
               end
            end
            rs485_dir_pkg::ST_TX: begin
               if (tx_frame_done & tx_last_reg) begin
                  state_next = (I_MASTER_MODE & ~tx_bcast_reg)
                               ? rs485_dir_pkg::ST_COLLECT
                               : rs485_dir_pkg::ST_LISTEN;
               end
            end
            rs485_dir_pkg::ST_COLLECT: begin
               if ((gap_hit & got_byte_reg) | (wait_done & ~got_byte_reg & ~rx_busy_reg)) begin
                  state_next = rs485_dir_pkg::ST_LISTEN;
               end
            end
            default: begin
               state_next = rs485_dir_pkg::ST_LISTEN;
            end
         endcase
      end
   end

   // Driver on only while originating; drops with the last stop bit
   assign dir_next = (state_next == rs485_dir_pkg::ST_TX);

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_reg <= rs485_dir_pkg::ST_LISTEN;
         dir_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         dir_reg   <= dir_next;
      end
   end

   // Classify each slave message by its address byte
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         keep_reg      <= 1'b0;
         addressed_reg <= 1'b0;
      end else if (first_byte) begin
         keep_reg      <= addr_match | bcast_match;
         addressed_reg <= addr_match & ~bcast_match;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         got_byte_reg <= 1'b0;
      end else if (state_reg != rs485_dir_pkg::ST_COLLECT) begin
         got_byte_reg <= 1'b0;
      end else if (rx_byte_stb_reg) begin
         got_byte_reg <= 1'b1;
      end
   end

   assign deliver = rx_byte_stb_reg &
                    (I_HOST_DIR_MODE
                     | (state_reg == rs485_dir_pkg::ST_COLLECT)
                     | ((state_reg == rs485_dir_pkg::ST_RX_MSG) & keep_reg));

   rx_skid_buffer #(
      .WIDTH (rs485_dir_pkg::DATA_W),
      .DEPTH (rs485_dir_pkg::RX_BUF_DEPTH)
   ) u_rx_buf (
      .clk        (I_CORE_CLK),
      .rst        (I_RST),
      .i_wr_data  (rx_shift_reg),
      .i_wr_valid (deliver),
      .o_wr_ready (buf_ready),
      .o_rd_data  (O_RX_DATA),
      .o_rd_valid (O_RX_VALID),
      .i_rd_ready (I_RX_READY)
   );

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         msg_end_reg  <= 1'b0;
         no_reply_reg <= 1'b0;
         overrun_reg  <= 1'b0;
      end else begin
         msg_end_reg  <= gap_hit & (((state_reg == rs485_dir_pkg::ST_RX_MSG) & keep_reg)
                                    | ((state_reg == rs485_dir_pkg::ST_COLLECT) & got_byte_reg));
         no_reply_reg <= (state_reg == rs485_dir_pkg::ST_COLLECT) & wait_done
                         & ~got_byte_reg & ~rx_busy_reg;
         overrun_reg  <= deliver & ~buf_ready;
      end
   end

   assign O_RS485_TX                  = tx_line_reg;
   assign O_DIRECTION_CONTROL_GPIO    = dir_reg;
   assign O_DIRECTION_CONTROL_GPIO_OE = ~I_HOST_DIR_MODE;
   assign O_TRANSMITTING              = dir_reg;
   assign O_REPLY_DUE                 = (state_reg == rs485_dir_pkg::ST_REPLY);
   assign O_MSG_END                   = msg_end_reg;
   assign O_NO_REPLY                  = no_reply_reg;
   assign O_RX_OVERRUN                = overrun_reg;
   assign O_FRAME_ERROR               = frame_err_reg;

endmodule

//--- verilog/rs485_dir_pkg.sv
package rs485_dir_pkg;

   // Core clock and serial rate
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned BAUD_DEF      = 115_200;
   localparam int unsigned OS_RATE       = 16;
   localparam int unsigned OS_MID        = 8;
   localparam int unsigned OS_DIV_DEF    = CLK_HZ / (BAUD_DEF * OS_RATE);
   localparam int unsigned FRAME_BITS    = 10;

   // Quiet line time that closes a message, in bit times
   localparam int unsigned EOM_GAP_BITS  = 30;
   localparam int unsigned EOM_GAP_TICKS = EOM_GAP_BITS * OS_RATE;

   // Longest wait for a reply, slave and master alike
   localparam int unsigned REPLY_WAIT_US  = 10_000;
   localparam int unsigned REPLY_WAIT_CYC = REPLY_WAIT_US * (CLK_HZ / 1_000_000);

   // Address carried by a message meant for every slave
   localparam logic [7:0]  BCAST_ADDR    = 8'hff;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned RX_BUF_DEPTH  = 2;

   typedef enum logic [2:0] {
      ST_LISTEN  = 3'h0,
      ST_RX_MSG  = 3'h1,
      ST_REPLY   = 3'h2,
      ST_TX      = 3'h3,
      ST_COLLECT = 3'h4
   } dir_state_t;

endpackage

//--- verilog/rx_skid_buffer.sv
`timescale 1ns/100ps
module rx_skid_buffer #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   // Drain side
   output logic      [WIDTH-1:0] o_rd_data,
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             wr_fire;
   logic             rd_fire;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign o_wr_ready = (count_reg != CW'(DEPTH));
   assign o_rd_valid = (count_reg != '0);
   assign o_rd_data  = mem_reg[rd_ptr_reg];
   assign wr_fire    = i_wr_valid & o_wr_ready;
   assign rd_fire    = o_rd_valid & i_rd_ready;

   always_ff @(posedge clk) begin
      if (wr_fire) begin
         mem_reg[wr_ptr_reg] <= i_wr_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (wr_fire) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         if (rd_fire) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         count_reg <= count_reg + CW'(wr_fire) - CW'(rd_fire);
      end
   end

endmodule

//--- sim/rs485_dir_props.sv
`timescale 1ns/100ps
module rs485_dir_props #(
   parameter int unsigned OS_DIV         = 2,
   parameter int unsigned REPLY_WAIT_CYC = 2000
) (
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   // Modes
   input wire logic I_MASTER_MODE,
   input wire logic I_HOST_DIR_MODE,
   // Lines and pin
   input wire logic I_RS485_RX,
   input wire logic O_RS485_TX,
   input wire logic I_DIRECTION_CONTROL_GPIO,
   input wire logic O_DIRECTION_CONTROL_GPIO,
   input wire logic O_DIRECTION_CONTROL_GPIO_OE,
   // Stream and status
   input wire logic I_TX_VALID,
   input wire logic O_TX_READY,
   input wire logic O_TRANSMITTING,
   input wire logic O_REPLY_DUE,
   input wire logic O_MSG_END,
   input wire logic O_NO_REPLY
);
   localparam int BIT_CYC   = rs485_dir_pkg::OS_RATE * OS_DIV;
   localparam int FRAME_CYC = rs485_dir_pkg::FRAME_BITS * BIT_CYC;
   localparam int GAP_CYC   = rs485_dir_pkg::EOM_GAP_BITS * BIT_CYC;
   localparam int RW        = REPLY_WAIT_CYC;

   logic        dir_reg;
   logic [20:0] frame_cnt;
   logic [20:0] quiet_cnt;
   logic [20:0] wait_cnt;

   // Cycles since last byte taken, since line went quiet, since release
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         dir_reg   <= 1'b0;
         frame_cnt <= 21'h0;
         quiet_cnt <= 21'h0;
         wait_cnt  <= 21'h0;
      end else begin
         dir_reg   <= O_TRANSMITTING;
         frame_cnt <= (I_TX_VALID && O_TX_READY) ? 21'h0 : frame_cnt + {20'h0, ~&frame_cnt};
         quiet_cnt <= !I_RS485_RX ? 21'h0 : quiet_cnt + {20'h0, ~&quiet_cnt};
         wait_cnt  <= (dir_reg && !O_TRANSMITTING) ? 21'h0 : wait_cnt + {20'h0, ~&wait_cnt};
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   sequence s_take;  I_TX_VALID && O_TX_READY;     endsequence
   sequence s_start; !O_RS485_TX;                   endsequence
   sequence s_quiet; quiet_cnt >= GAP_CYC;          endsequence
   sequence s_end;   O_MSG_END || $past(O_MSG_END); endsequence

   property p_pin_follow;
      O_DIRECTION_CONTROL_GPIO_OE == !I_HOST_DIR_MODE
         && O_DIRECTION_CONTROL_GPIO == O_TRANSMITTING;
   endproperty
   property p_start_dir;
      !I_HOST_DIR_MODE && $fell(O_RS485_TX) |-> O_TRANSMITTING;
   endproperty
   property p_idle_high;
      !I_HOST_DIR_MODE && !O_TRANSMITTING |-> O_RS485_TX;
   endproperty
   property p_take_start;
      s_take |=> s_start;
   endproperty
   property p_slave_speaks;
      !I_MASTER_MODE && !I_HOST_DIR_MODE && O_TX_READY
         |-> O_REPLY_DUE || $past(O_REPLY_DUE) || O_TRANSMITTING;
   endproperty
   property p_host_gate;
      I_HOST_DIR_MODE && O_TX_READY |-> I_DIRECTION_CONTROL_GPIO;
   endproperty
   property p_release;
      !I_HOST_DIR_MODE && $fell(O_TRANSMITTING)
         |-> frame_cnt >= FRAME_CYC - 2 && frame_cnt <= FRAME_CYC + 3;
   endproperty
   property p_reply_gap;
      $rose(O_REPLY_DUE) |-> s_quiet and (s_end or (##1 O_MSG_END));
   endproperty
   property p_no_reply;
      O_NO_REPLY |-> I_MASTER_MODE && wait_cnt >= RW - 3 && wait_cnt <= RW + 3;
   endproperty

   a_pin_follow: assert property (p_pin_follow)
      else $error("direction pin does not follow state");
   a_start_dir: assert property (p_start_dir)
      else $error("start bit without direction high");
   a_idle_high: assert property (p_idle_high)
      else $error("line driven low while listening");
   a_take_start: assert property (p_take_start)
      else $error("taken byte did not start");
   a_slave_speaks: assert property (p_slave_speaks)
      else $error("slave ready without addressed message");
   a_host_gate: assert property (p_host_gate)
      else $error("ready while host holds pin low");
   a_release: assert property (p_release)
      else $error("direction released at wrong time");
   a_reply_gap: assert property (p_reply_gap)
      else $error("reply due before message ended");
   a_no_reply: assert property (p_no_reply)
      else $error("no reply flagged at wrong time");
endmodule

bind rs485_half_duplex_direction_ctrl rs485_dir_props #(
   .OS_DIV         (OS_DIV),
   .REPLY_WAIT_CYC (REPLY_WAIT_CYC)
) props_i (
   .I_CORE_CLK                  (I_CORE_CLK),
   .I_RST                       (I_RST),
   .I_MASTER_MODE               (I_MASTER_MODE),
   .I_HOST_DIR_MODE             (I_HOST_DIR_MODE),
   .I_RS485_RX                  (I_RS485_RX),
   .O_RS485_TX                  (O_RS485_TX),
   .I_DIRECTION_CONTROL_GPIO    (I_DIRECTION_CONTROL_GPIO),
   .O_DIRECTION_CONTROL_GPIO    (O_DIRECTION_CONTROL_GPIO),
   .O_DIRECTION_CONTROL_GPIO_OE (O_DIRECTION_CONTROL_GPIO_OE),
   .I_TX_VALID                  (I_TX_VALID),
   .O_TX_READY                  (O_TX_READY),
   .O_TRANSMITTING              (O_TRANSMITTING),
   .O_REPLY_DUE                 (O_REPLY_DUE),
   .O_MSG_END                   (O_MSG_END),
   .O_NO_REPLY                  (O_NO_REPLY)
);

//--- sim/far_node_model.sv
`timescale 1ns/100ps
module far_node_model #(
   parameter int unsigned BIT_CYC = 32
) (
   // Clock
   input  wire logic clk,
   // Node line and resolved direction pin
   input  wire logic i_tx,
   input  wire logic i_dir,
   output logic      o_line
);
   logic [7:0] got_q[$];
   int         clash_cnt;
   logic [7:0] rx_b;

   // Failsafe bias holds the idle bus high
   initial begin
      o_line    = 1'b1;
      clash_cnt = 0;
   end

   // Speaks one frame; counts a clash if the node's direction is not low
   task automatic send(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      if (i_dir !== 1'b0) clash_cnt++;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         #1 o_line = fr[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask

   // Samples node frames mid-bit while its direction is high
   always @(negedge i_tx) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      if (i_dir === 1'b1) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            rx_b[i] = i_tx;
         end
         got_q.push_back(rx_b);
      end
   end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   localparam int unsigned OS_DIV = 2;
   localparam int unsigned RW     = 2000;
   localparam int unsigned BIT    = rs485_dir_pkg::OS_RATE * OS_DIV;
   localparam int unsigned FRAME  = 10 * BIT;
   localparam int unsigned GAP    = rs485_dir_pkg::EOM_GAP_BITS * BIT;
   localparam logic [7:0]  ADDR   = 8'h21;

   logic       clk, rst, master, host, pin_host, tx_last, tx_valid, rx_ready;
   logic       line, tx, dir_o, dir_oe, tx_ready, rx_valid, transmitting;
   logic       reply_due, msg_end, no_reply, overrun, frame_err;
   logic [7:0] node_addr, tx_data, rx_data;
   wire        pin = dir_oe ? dir_o : pin_host;
   int         err_total, check_count;
   logic       seen_end, seen_due, seen_nr, seen_ov, seen_rdy, seen_fe;
   logic [7:0] rx_q[$];

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   rs485_half_duplex_direction_ctrl #(.OS_DIV(OS_DIV), .REPLY_WAIT_CYC(RW))
   rs485_half_duplex_direction_ctrl_i (
      .I_CORE_CLK(clk), .I_RST(rst), .I_MASTER_MODE(master), .I_HOST_DIR_MODE(host),
      .I_NODE_ADDR(node_addr), .I_RS485_RX(line), .O_RS485_TX(tx),
      .I_DIRECTION_CONTROL_GPIO(pin), .O_DIRECTION_CONTROL_GPIO(dir_o),
      .O_DIRECTION_CONTROL_GPIO_OE(dir_oe), .I_TX_DATA(tx_data), .I_TX_LAST(tx_last),
      .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .O_RX_DATA(rx_data),
      .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_TRANSMITTING(transmitting),
      .O_REPLY_DUE(reply_due), .O_MSG_END(msg_end), .O_NO_REPLY(no_reply),
      .O_RX_OVERRUN(overrun), .O_FRAME_ERROR(frame_err));

   far_node_model #(.BIT_CYC(BIT)) far_node_model_i (
      .clk(clk), .i_tx(tx), .i_dir(pin), .o_line(line));

   // Sticky status and drained bytes
   always @(posedge clk) begin
      if (msg_end === 1'b1) seen_end = 1'b1;
      if (reply_due === 1'b1) seen_due = 1'b1;
      if (no_reply === 1'b1) seen_nr = 1'b1;
      if (overrun === 1'b1) seen_ov = 1'b1;
      if (tx_ready === 1'b1) seen_rdy = 1'b1;
      if (frame_err === 1'b1) seen_fe = 1'b1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic clr();
      {seen_end, seen_due, seen_nr, seen_ov, seen_rdy, seen_fe} = 6'h0;
      rx_q.delete();
      far_node_model_i.got_q.delete();
   endtask

   // Holds the byte until taken; caller drops valid after the last
   task automatic tx_send(input logic [7:0] b, input logic last);
      int n;
      tx_data = b;
      tx_last = last;
      tx_valid = 1'b1;
      n = 0;
      while (tx_ready !== 1'b1 && n < 4000) begin
         tick(1);
         n++;
      end
      `CHK(tx_ready, 1'b1)
      tick(1);
   endtask

   task automatic wait_got(input int k);
      for (int n = 0; n < 5000 && far_node_model_i.got_q.size() < k; n++) tick(1);
   endtask

   task automatic wait_rel();
      for (int n = 0; n < 2000 && dir_o !== 1'b0; n++) tick(1);
      tick(2);
   endtask

   task automatic t_reset_vals();
      `CHK(tx, 1'b1)
      `CHK(dir_o, 1'b0)
      `CHK(dir_oe, 1'b1)
      `CHK(rx_valid, 1'b0)
   endtask

   task automatic t_slave_addr(input logic [7:0] a);
      clr();
      node_addr = a;
      fork
         tx_send(a ^ 8'h7b, 1'b1);
         begin
            far_node_model_i.send(a);
            far_node_model_i.send(8'ha5);
            far_node_model_i.send(8'h3c);
         end
      join
      tx_valid = 1'b0;
      `CHK(seen_end, 1'b1)
      `CHK(seen_due, 1'b1)
      `CHK(rx_q.size(), 2)
      `CHK(rx_q[0], 8'ha5)
      `CHK(rx_q[1], 8'h3c)
      wait_got(1);
      `CHK(far_node_model_i.got_q[0], a ^ 8'h7b)
      wait_rel();
      `CHK(pin, 1'b0)
   endtask

   // Foreign address, then broadcast, with a byte offered throughout
   task automatic t_slave_filter();
      clr();
      tx_data = 8'h5a;
      tx_last = 1'b1;
      tx_valid = 1'b1;
      far_node_model_i.send(8'h22);
      far_node_model_i.send(8'h11);
      tick(GAP + 200);
      far_node_model_i.send(rs485_dir_pkg::BCAST_ADDR);
      far_node_model_i.send(8'h77);
      tick(GAP + 200);
      `CHK(seen_rdy, 1'b0)
      `CHK(seen_due, 1'b0)
      `CHK(seen_end, 1'b1)
      `CHK(rx_q.size(), 1)
      `CHK(rx_q[0], 8'h77)
      `CHK(tx, 1'b1)
      tx_valid = 1'b0;
   endtask

   task automatic t_master();
      master = 1'b1;
      clr();
      for (int k = 0; k < 2; k++) tx_send(k ? 8'h42 : ADDR, k[0]);
      tx_valid = 1'b0;
      wait_got(2);
      wait_rel();
      `CHK(far_node_model_i.got_q[0], ADDR)
      `CHK(far_node_model_i.got_q[1], 8'h42)
      `CHK(pin, 1'b0)
      far_node_model_i.send(8'h99);
      tick(GAP + 200);
      `CHK(seen_end, 1'b1)
      `CHK(rx_q[0], 8'h99)
      `CHK(seen_nr, 1'b0)
      clr();
      tx_send(ADDR, 1'b1);
      tx_valid = 1'b0;
      tick(RW + 2 * FRAME);
      `CHK(seen_nr, 1'b1)
      clr();
      tx_send(rs485_dir_pkg::BCAST_ADDR, 1'b1);
      tx_valid = 1'b0;
      tick(RW + 2 * FRAME);
      `CHK(seen_nr, 1'b0)
      master = 1'b0;
   endtask

   // Host holds pin low, buffer overfills, then host lets us answer
   task automatic t_host();
      host = 1'b1;
      rx_ready = 1'b0;
      clr();
      tx_data = 8'h66;
      tx_last = 1'b1;
      tx_valid = 1'b1;
      tick(2);
      `CHK(dir_oe, 1'b0)
      far_node_model_i.send(8'h44);
      far_node_model_i.send(8'h45);
      far_node_model_i.send(8'h46);
      tick(BIT);
      `CHK(seen_ov, 1'b1)
      `CHK(seen_rdy, 1'b0)
      rx_ready = seen_ov;
      tick(4);
      `CHK(rx_q.size(), 2)
      `CHK(rx_q[0], 8'h44)
      `CHK(rx_valid, 1'b0)
      pin_host = 1'b1;
      tx_send(8'h66, 1'b1);
      tx_valid = 1'b0;
      wait_got(1);
      `CHK(far_node_model_i.got_q[0], 8'h66)
      tick(2 * BIT);
      pin_host = 1'b0;
      // Line held low through the stop bit sample, released before its end
      far_node_model_i.o_line = 1'b0;
      tick(FRAME - BIT / 4);
      far_node_model_i.o_line = 1'b1;
      tick(BIT);
      `CHK(seen_fe, 1'b1)
      host = 1'b0;
   endtask

   task automatic stop_test();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      err_total = 0;
      check_count = 0;
      {rst, master, host, pin_host, tx_last, tx_valid, rx_ready} = 7'h41;
      node_addr = ADDR;
      tx_data = 8'h00;
      tick(8);
      rst = 1'b0;
      t_reset_vals();
      t_slave_addr(ADDR);
      t_slave_addr(~ADDR);
      t_slave_filter();
      t_master();
      t_host();
      `CHK(far_node_model_i.clash_cnt, 0)
      stop_test();
   end

   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
